// ### logic/cmd_buffer.sv
// Registered command/address buffer with select gating and parity check
`timescale 1ns/1ps
`include "cmd_buffer_cfg.svh"

// Overview of operation
// (RQ1) Reset clears registers, outputs low, flag high
// (RQ2) Config select picks the checked input set
// (RQ3) Capture at differential clock crossing
// (RQ4) Gate low: redrive command bits every edge
// (RQ5) Gate high: update only if select low
// (RQ6) Gate and selects high: hold command outputs
// (RQ7) Termination and clock enable never suspended
// (RQ8) Chip selects registered every edge
// (RQ9) Parity bit arrives one cycle after data
// (RQ10) Odd ones count flags error low
// (RQ11) Error appears two cycles after registration
// (RQ12) Single error latches low two cycles
// (RQ13) Consecutive errors keep flag low throughout
// (RQ14) Gate enable ignored by parity check
// (RQ15) Standby: no check, flag holds value
// (RQ16) Error before standby holds through plus two
// (RQ17) Controller keeps inputs valid after reset
// (RQ18) Controller drives inputs low after release
// (RQ19) Flag updated n+2, valid by n+3
// (RQ20) Without qualifying edge outputs hold
module cmd_buffer (
  input  wire logic                      i_clk,
  input  wire logic                      i_resetn,
  input  wire logic                      i_config_select,
  input  wire logic                      i_select_gate_enable,
  input  wire cmd_buffer_pkg::cmd_word_t i_cmd_addr_inputs,
  input  wire logic                      i_chip_select_in_zero_n,
  input  wire logic                      i_chip_select_in_one_n,
  input  wire logic                      i_termination_in_zero,
  input  wire logic                      i_termination_in_one,
  input  wire logic                      i_clock_enable_in_zero,
  input  wire logic                      i_clock_enable_in_one,
  input  wire logic                      i_parity_bit_in,
  output cmd_buffer_pkg::cmd_word_t      o_cmd_addr_outputs_a,
  output cmd_buffer_pkg::cmd_word_t      o_cmd_addr_outputs_b,
  output logic                           o_chip_select_out_zero_n,
  output logic                           o_chip_select_out_one_n,
  output logic                           o_termination_out_zero,
  output logic                           o_termination_out_one,
  output logic                           o_clock_enable_out_zero,
  output logic                           o_clock_enable_out_one,
  output logic                           o_standby_state,
  output logic                           o_parity_error_flag_n,
  output logic                           o_parity_error_oe
);
  import cmd_buffer_pkg::*;

  // Inputs are same-clock logic: the differential crossing is i_clk rising
  cmd_word_t  cmd_q;
  cmd_word_t  next_cmd_q;
  logic       cs0_q;
  logic       cs1_q;
  logic       odt0_q;
  logic       odt1_q;
  logic       cke0_q;
  logic       cke1_q;
  logic       standby;
  logic       next_standby;
  cmd_word_t  chk_word;
  cmd_word_t  next_chk_word;
  logic       chk_valid;
  logic       next_chk_valid;
  logic       odd;
  logic       err_now;
  logic       flag_n;
  logic       next_flag_n;
  logic [1:0] hold_cnt;
  logic [1:0] next_hold_cnt;
  err_state_t state;
  err_state_t next_state;
  logic       qualified;
  logic       err_q;
  logic       next_err_q;
  logic       cfg_sync;

  // Config strap is a slow pin: it reaches the parity map four clocks late,
  // so it must be settled before checked traffic starts
  sync_bit u_cfg_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_pin    (i_config_select),
    .o_level  (cfg_sync)
  );

  parity_tree u_parity (
    .i_word          (chk_word),
    .i_config_select (cfg_sync),
    .i_parity_bit    (i_parity_bit_in),
    .o_odd           (odd)
  );

  // A select low at this edge qualifies the cycle; gate enable plays no part
  assign qualified = !i_chip_select_in_zero_n || !i_chip_select_in_one_n;
  assign err_now   = err_q; // [RQ11]

  always_comb begin
    next_cmd_q     = cmd_q;
    next_standby   = i_select_gate_enable && !qualified; // [RQ15]
    if (!i_select_gate_enable || qualified) begin
      next_cmd_q = i_cmd_addr_inputs; // [RQ4] [RQ5]
    end
    // Else the receivers count as off and outputs hold [RQ6]
    // Word is kept for one cycle so the late parity bit meets it [RQ9]
    next_chk_word  = i_cmd_addr_inputs;
    next_chk_valid = qualified;
    // Second stage puts the flag edge at n+2, as the bit only arrives at n+1
    next_err_q     = chk_valid && odd; // [RQ14]
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin // [RQ1]
      cmd_q     <= '0;
      cs0_q     <= 1'b0;
      cs1_q     <= 1'b0;
      odt0_q    <= 1'b0;
      odt1_q    <= 1'b0;
      cke0_q    <= 1'b0;
      cke1_q    <= 1'b0;
      standby   <= 1'b0;
      chk_word  <= '0;
      chk_valid <= 1'b0;
      err_q     <= 1'b0;
    end else begin // [RQ3]
      cmd_q     <= next_cmd_q;
      cs0_q     <= i_chip_select_in_zero_n; // [RQ8]
      cs1_q     <= i_chip_select_in_one_n;
      odt0_q    <= i_termination_in_zero; // [RQ7]
      odt1_q    <= i_termination_in_one;
      cke0_q    <= i_clock_enable_in_zero;
      cke1_q    <= i_clock_enable_in_one;
      standby   <= next_standby;
      chk_word  <= next_chk_word;
      chk_valid <= next_chk_valid;
      err_q     <= next_err_q;
    end
  end

  // Error flag sequencer: flag falls one edge after the registered check,
  // i.e. n+2 for a word captured at edge n [RQ11] [RQ19]
  always_comb begin
    next_state    = state;
    next_flag_n   = flag_n;
    next_hold_cnt = hold_cnt;
    case (state)
      ERR_IDLE: begin
        if (err_now) begin
          // An error seen as standby starts still gets the stretch [RQ16]
          next_state    = standby ? ERR_SLEEP : ERR_HOLD;
          next_flag_n   = 1'b0;
          next_hold_cnt = `ERR_HOLD_CYCLES - 2'h1;
        end
      end
      ERR_HOLD: begin
        if (standby) begin // [RQ16]
          next_state    = ERR_SLEEP;
          next_hold_cnt = `ERR_HOLD_CYCLES;
        end else if (err_now) begin // [RQ13]
          next_hold_cnt = `ERR_HOLD_CYCLES - 2'h1;
        end else if (hold_cnt != 2'h0) begin // [RQ12]
          next_hold_cnt = hold_cnt - 2'h1;
        end else begin
          next_state  = ERR_IDLE;
          next_flag_n = 1'b1;
        end
      end
      ERR_SLEEP: begin
        // Flag stays low while in standby, then two more cycles
        if (!standby) begin
          next_state    = ERR_HOLD;
          next_hold_cnt = `ERR_HOLD_CYCLES - 2'h1;
        end
      end
      default: begin
        next_state  = ERR_IDLE;
        next_flag_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state    <= ERR_IDLE;
      flag_n   <= 1'b1;
      hold_cnt <= 2'h0;
    end else begin // [RQ20]
      state    <= next_state;
      flag_n   <= next_flag_n;
      hold_cnt <= next_hold_cnt;
    end
  end

  // Both output banks carry the same registered word
  assign o_cmd_addr_outputs_a    = cmd_q;
  assign o_cmd_addr_outputs_b    = cmd_q;
  assign o_chip_select_out_zero_n = cs0_q;
  assign o_chip_select_out_one_n  = cs1_q;
  assign o_termination_out_zero  = odt0_q;
  assign o_termination_out_one   = odt1_q;
  assign o_clock_enable_out_zero = cke0_q;
  assign o_clock_enable_out_one  = cke1_q;
  assign o_standby_state         = standby;
  // Open drain: enable pulls low, released means high
  assign o_parity_error_flag_n   = flag_n;
  assign o_parity_error_oe       = !flag_n;

  chk_reset_clear: assert property (@(posedge i_clk) // [RQ1]
    !i_resetn |=> (cmd_q == '0) && flag_n && !odt0_q)
    else $error("reset did not clear outputs");

  chk_ungated_pass: assert property (@(posedge i_clk) // [RQ4]
    disable iff (!i_resetn)
    !i_select_gate_enable |=> cmd_q == $past(i_cmd_addr_inputs))
    else $error("ungated command word not redriven");

  chk_gated_hold: assert property (@(posedge i_clk) // [RQ6]
    disable iff (!i_resetn)
    (i_select_gate_enable && !qualified) |=> $stable(cmd_q))
    else $error("command outputs changed while gated");

  chk_select_follow: assert property (@(posedge i_clk) // [RQ8]
    disable iff (!i_resetn)
    1'b1 |=> cs1_q == $past(i_chip_select_in_one_n))
    else $error("chip select output not registered");

  chk_odt_follow: assert property (@(posedge i_clk) // [RQ7]
    disable iff (!i_resetn)
    1'b1 |=> odt1_q == $past(i_termination_in_one))
    else $error("termination output suspended");

  chk_err_latency: assert property (@(posedge i_clk) // [RQ11]
    disable iff (!i_resetn)
    qualified ##1 (odd && chk_valid) |=> ##1 !flag_n)
    else $error("error flag not low two cycles after word");

  chk_err_min_low: assert property (@(posedge i_clk) // [RQ12]
    disable iff (!i_resetn)
    $fell(flag_n) |=> !flag_n)
    else $error("error flag released before two cycles");

  chk_err_persist: assert property (@(posedge i_clk) // [RQ13]
    disable iff (!i_resetn)
    err_now |=> !flag_n)
    else $error("error flag high during persisting errors");

  chk_standby_hold: assert property (@(posedge i_clk) // [RQ16]
    disable iff (!i_resetn)
    (!flag_n && standby) |=> !flag_n)
    else $error("error flag released during standby");

  chk_clean_release: assert property (@(posedge i_clk) // [RQ15]
    disable iff (!i_resetn)
    (flag_n && !err_now) |=> flag_n)
    else $error("error flag fell without a parity error");

  chk_select_zero: assert property (@(posedge i_clk) // [RQ8]
    disable iff (!i_resetn)
    1'b1 |=> cs0_q == $past(i_chip_select_in_zero_n))
    else $error("chip select zero output not registered");

  chk_odt_zero: assert property (@(posedge i_clk) // [RQ7]
    disable iff (!i_resetn)
    1'b1 |=> odt0_q == $past(i_termination_in_zero))
    else $error("termination zero output suspended");

  chk_cke_follow: assert property (@(posedge i_clk) // [RQ7]
    disable iff (!i_resetn)
    1'b1 |=> {cke0_q, cke1_q} == $past({i_clock_enable_in_zero, i_clock_enable_in_one}))
    else $error("clock enable output suspended");

  chk_gated_pass: assert property (@(posedge i_clk) // [RQ5]
    disable iff (!i_resetn)
    (i_select_gate_enable && qualified) |=> cmd_q == $past(i_cmd_addr_inputs))
    else $error("selected command word not redriven");

  chk_standby_entry: assert property (@(posedge i_clk) // [RQ15]
    disable iff (!i_resetn)
    (i_select_gate_enable && !qualified) |=> standby)
    else $error("standby not entered");

  chk_standby_exit: assert property (@(posedge i_clk) // [RQ15]
    disable iff (!i_resetn)
    qualified |=> !standby)
    else $error("standby kept with a select low");

  chk_sleep_release: assert property (@(posedge i_clk) // [RQ16]
    disable iff (!i_resetn)
    (!flag_n && !standby && $past(standby)) |=> !flag_n ##1 !flag_n)
    else $error("error flag released too soon after standby");

  chk_single_release: assert property (@(posedge i_clk) // [RQ12]
    disable iff (!i_resetn)
    ($fell(flag_n) && state == ERR_HOLD && !err_now && !standby)
      ##1 (!err_now && !standby) |=> flag_n)
    else $error("single error flag not released after two cycles");

  chk_even_no_error: assert property (@(posedge i_clk) // [RQ10]
    disable iff (!i_resetn)
    (chk_valid && !odd && flag_n && !err_now) |=> ##1 flag_n)
    else $error("error flag fell for an even-parity word");
endmodule : cmd_buffer

// ### logic/cmd_buffer_cfg.svh
// Constants for the registered command buffer with parity check
`ifndef CMD_BUFFER_CFG_SVH
`define CMD_BUFFER_CFG_SVH
`define CA_WIDTH          28
`define CHECK_MASK_CFG0   28'hFFF0F5F
`define CHECK_MASK_CFG1   28'hFAF0FFF
`define ERR_HOLD_CYCLES   2'h2
`define CLK_PERIOD_PS     25000
`define T_INACT_NS        15
`define T_INACT_CYCLES    ((`T_INACT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`endif

// ### logic/cmd_buffer_pkg.sv
// Types for the registered command buffer with parity check
package cmd_buffer_pkg;
  typedef logic [27:0] cmd_word_t;
  typedef enum logic [2:0] {
    ERR_IDLE  = 3'h1,
    ERR_HOLD  = 3'h2,
    ERR_SLEEP = 3'h4
  } err_state_t;
endpackage : cmd_buffer_pkg

// ### logic/sync_bit.sv
// Three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ps
module sync_bit (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_pin,
  output logic      o_level
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  always_comb begin
    next_level = o_level;
    if (s2 == s3) begin
      next_level = s3;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      s1      <= 1'b0;
      s2      <= 1'b0;
      s3      <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1      <= i_pin;
      s2      <= s1;
      s3      <= s2;
      o_level <= next_level;
    end
  end
endmodule : sync_bit

// ### logic/parity_tree.sv
// Even-parity reduction over the selected command bits
`timescale 1ns/1ps
`include "cmd_buffer_cfg.svh"
module parity_tree (
  input  wire cmd_buffer_pkg::cmd_word_t i_word,
  input  wire logic                      i_config_select,
  input  wire logic                      i_parity_bit,
  output logic                           o_odd
);
  import cmd_buffer_pkg::*;
  cmd_word_t mask;

  always_comb begin
    // Bit k of the mask stands for input number k+1 [RQ2]
    mask  = i_config_select ? cmd_word_t'(`CHECK_MASK_CFG1)
                            : cmd_word_t'(`CHECK_MASK_CFG0);
    o_odd = ^(i_word & mask) ^ i_parity_bit; // [RQ10]
  end
endmodule : parity_tree

// ### sim/ctrl_model.sv
// Controller model: even parity trailing each command word
`timescale 1ns/1ps
module ctrl_model (
  input  wire logic                      i_clk,
  input  wire logic                      i_resetn,
  input  wire logic                      i_flip,
  input  wire cmd_buffer_pkg::cmd_word_t i_word,
  input  wire cmd_buffer_pkg::cmd_word_t i_mask,
  output logic                           o_parity
);
  import cmd_buffer_pkg::*;
  // Held low in reset so no false error follows release
  always @(posedge i_clk) begin
    o_parity <= i_resetn & ((^(i_word & i_mask)) ^ i_flip);
  end
endmodule : ctrl_model

// ### sim/testbench.sv
// Self-checking bench for the registered command buffer
`timescale 1ns/1ps
`include "cmd_buffer_cfg.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED at %0t: value mismatch", $time); end end
module testbench;
  import cmd_buffer_pkg::*;
  logic        clk = 1'b0;
  logic        rn, cfg, gate, cs0, cs1, flip, par, flag_n, cfg_v, oe;
  logic [3:0]  oc;
  logic [6:0]  side;
  logic [31:0] r;
  cmd_word_t   word, mask, mask_v, ref_word, qa, qb;
  logic [34:0] exp_q[$];
  logic [34:0] e;
  int          error_cnt = 0, checks = 0, seed = 32'h5CB0;
  int          cyc = 0, run = 0, last_run = 0, fall_cyc = 0;

  always #12.5 clk = ~clk;

  cmd_buffer cmd_buffer_inst (.i_clk(clk), .i_resetn(rn),
    .i_config_select(cfg), .i_select_gate_enable(gate),
    .i_cmd_addr_inputs(word), .i_chip_select_in_zero_n(cs0),
    .i_chip_select_in_one_n(cs1), .i_termination_in_zero(oc[3]),
    .i_termination_in_one(oc[2]), .i_clock_enable_in_zero(oc[1]),
    .i_clock_enable_in_one(oc[0]), .i_parity_bit_in(par),
    .o_cmd_addr_outputs_a(qa), .o_cmd_addr_outputs_b(qb),
    .o_chip_select_out_zero_n(side[6]), .o_chip_select_out_one_n(side[5]),
    .o_termination_out_zero(side[4]), .o_termination_out_one(side[3]),
    .o_clock_enable_out_zero(side[2]), .o_clock_enable_out_one(side[1]),
    .o_standby_state(side[0]), .o_parity_error_flag_n(flag_n),
    .o_parity_error_oe(oe));
  ctrl_model ctrl_model_inst (.i_clk(clk), .i_resetn(rn), .i_flip(flip),
    .i_word(word), .i_mask(mask), .o_parity(par));

  task complete_run;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  // One cycle of stimulus; its expected outputs are queued
  task step(input logic rv, g, c0, c1, input cmd_word_t w,
            input logic [3:0] o, input logic f);
    @(posedge clk);
    rn <= rv; gate <= g; cs0 <= c0; cs1 <= c1; word <= w;
    oc <= o; flip <= f; cfg <= cfg_v; mask <= mask_v;
    if (!rv) ref_word = '0;
    else if (!g || !c0 || !c1) ref_word = w;
    exp_q.push_back({ref_word, {c0, c1, o, g & c0 & c1} & {7{rv}}});
  endtask : step

  always @(negedge clk) begin
    cyc++;
    if (exp_q.size() > 1) begin
      e = exp_q.pop_front();
      `CHK(qa, e[34:7])
      `CHK(qb, e[34:7])
      `CHK(side, e[6:0])
      `CHK(oe, ~flag_n)
    end
    if (flag_n === 1'b0) begin
      if (run == 0) fall_cyc = cyc;
      run++;
    end else if (run > 0) begin
      last_run = run;
      run = 0;
    end
  end

  // Words n with parity flip f, then sleep standby cycles
  task run_err(input string nm, input logic c, g, input cmd_word_t m, w,
               input int n, input logic f, input int sleep, lo, ex);
    int d;
    cfg_v = c; mask_v = m; last_run = 0; fall_cyc = 0;
    // Strap needs four clocks through its synchroniser
    repeat (4) step(1'b1, g, 1'b0, 1'b1, '0, 4'h0, 1'b0);
    d = cyc + 5;
    repeat (n) step(1'b1, g, 1'b0, 1'b1, w, 4'h5, f);
    repeat (sleep) step(1'b1, 1'b1, 1'b1, 1'b1, '0, 4'hA, 1'b0);
    repeat (8) step(1'b1, g, 1'b1, 1'b0, '0, 4'h3, 1'b0);
    `CHK(fall_cyc, lo ? d : 0)
    `CHK(ex ? last_run == lo : last_run >= lo, 1'b1)
    $display("test %s done", nm);
  endtask : run_err

  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end

  initial begin
    rn = 1'b0; cfg = 1'b0; gate = 1'b0; cs0 = 1'b1; cs1 = 1'b1; flip = 1'b0;
    word = '0; mask = '0; oc = 4'h0; cfg_v = 1'b0; mask_v = `CHECK_MASK_CFG0;
    repeat (20) step(1'b0, 1'b0, 1'b1, 1'b1, '0, 4'h0, 1'b0);
    repeat (4) step(1'b1, 1'b0, 1'b1, 1'b1, '0, 4'h0, 1'b0);
    for (int i = 0; i < 300; i++) begin
      r = $random(seed);
      step(1'b1, r[0], r[1], r[2], r[31:4], r[7:4], 1'b0);
    end
    `CHK(fall_cyc, 0)
    $display("test random done");
    run_err("single", 0, 0, `CHECK_MASK_CFG0, 28'h1, 1, 1, 0, 2, 1);
    run_err("gated", 0, 1, `CHECK_MASK_CFG0, 28'h3, 1, 1, 0, 2, 1);
    run_err("burst", 1, 0, `CHECK_MASK_CFG1, 28'h7, 3, 1, 0, 3, 0);
    run_err("standby", 0, 0, `CHECK_MASK_CFG0, 28'h1, 1, 1, 5, 6, 0);
    // Unmasked parity exposes which inputs each map checks
    for (int c = 0; c < 2; c++)
      run_err("map", c[0], 0, 28'hFFFFFFF, 28'h20, 1, 0, 0, c ? 0 : 2, 1);
    cfg_v = 1'b0;
    mask_v = `CHECK_MASK_CFG0;
    step(1'b1, 1'b0, 1'b0, 1'b1, 28'h1, 4'h0, 1'b1);
    // Reset lands while the flag is still held low
    repeat (2) step(1'b1, 1'b0, 1'b0, 1'b1, '0, 4'h0, 1'b0);
    repeat (2) step(1'b0, 1'b0, 1'b1, 1'b1, '0, 4'h0, 1'b0);
    #1;
    `CHK(flag_n, 1'b1)
    repeat (6) step(1'b1, 1'b0, 1'b1, 1'b1, '0, 4'h0, 1'b0);
    $display("test reset done");
    complete_run();
  end
endmodule : testbench
